/* logic/lkprt_pkg.sv */
// Constants, types and register layout for the lookup RAM access port.
// Assumes a single 100 MHz register clock and an APB master with 32-bit
// data; every register takes one aligned word at four times its index.
package lkprt_pkg;

   // ---------------------------------------------------------------
   // Widths
   // ---------------------------------------------------------------
   localparam int unsigned LKP_ADDR_W = 7;
   localparam int unsigned LKP_DATA_W = 8;
   localparam int unsigned LKP_DEPTH = 128;
   localparam int unsigned APB_ADDR_W = 16;
   localparam int unsigned APB_DATA_W = 32;

   // ---------------------------------------------------------------
   // Register indices and byte addresses
   // ---------------------------------------------------------------
   localparam logic [15:0] IDX_ADDR_CTRL = 16'h2887;
   localparam logic [15:0] IDX_DATA = 16'h2888;
   localparam logic [15:0] IDX_STROBES = 16'h2889;
   localparam logic [15:0] BADDR_ADDR_CTRL = {IDX_ADDR_CTRL[13:0], 2'b00};
   localparam logic [15:0] BADDR_DATA = {IDX_DATA[13:0], 2'b00};
   localparam logic [15:0] BADDR_STROBES = {IDX_STROBES[13:0], 2'b00};

   // ---------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------
   localparam int unsigned AUTO_INC_BIT = 7;
   localparam int unsigned RD_STROBE_BIT = 1;
   localparam int unsigned WR_STROBE_BIT = 0;
   localparam logic [7:0] RST_ADDR_CTRL = 8'h00;
   localparam logic [7:0] RST_DATA = 8'h00;
   localparam logic [7:0] RST_STROBES = 8'h00;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned ACCESS_TIME_NS = 30;
   // Least time, rounded up to whole cycles.
   localparam int unsigned ACCESS_CYCLES =
      (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0]
   {
      SEQ_IDLE = 2'b00,
      SEQ_ISSUE = 2'b01,
      SEQ_WAIT = 2'b10,
      SEQ_DONE = 2'b11
   } lkprt_seq_state_t;

   typedef enum logic [1:0]
   {
      SEL_NONE = 2'b00,
      SEL_ADDR_CTRL = 2'b01,
      SEL_DATA = 2'b10,
      SEL_STROBES = 2'b11
   } lkprt_sel_t;

   typedef struct packed
   {
      logic valid;
      logic write;
      logic [6:0] addr;
      logic [7:0] wdata;
   } lkprt_ram_req_t;

endpackage : lkprt_pkg

/* logic/lkprt_ram.sv */
// Byte-wide lookup RAM of 128 locations with synchronous read.
// Assumes requests come from the access sequencer on the same clock.
`timescale 1ns/100ps
module lkprt_ram
(
   input wire logic clk,
   input wire lkprt_pkg::lkprt_ram_req_t req,
   output logic [7:0] rdata
);
   import lkprt_pkg::*;

   logic [LKP_DATA_W-1:0] mem [0:LKP_DEPTH-1];
   logic [7:0] rdata_r;

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   // Contents are not reset, as in a real macro; software loads them.
   always_ff @(posedge clk)
   begin
      if (req.valid && req.write)
      begin
         mem[req.addr] <= req.wdata;
      end
   end

   always_ff @(posedge clk)
   begin
      if (req.valid && !req.write)
      begin
         rdata_r <= mem[req.addr];
      end
   end

   assign rdata = rdata_r;

endmodule : lkprt_ram

/* logic/lkprt_seq.sv */
// Sequencer that runs one lookup RAM access per start pulse and then
// reports completion with a one-cycle done pulse and the fetched byte.
// Assumes start pulses only arrive while it is idle.
`timescale 1ns/100ps
module lkprt_seq
(
   input wire logic clk,
   input wire logic srst,
   input wire logic start,
   input wire logic start_write,
   input wire logic [6:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] ram_rdata,
   output lkprt_pkg::lkprt_ram_req_t ram_req,
   output logic done,
   output logic [7:0] rd_byte
);
   import lkprt_pkg::*;

   lkprt_seq_state_t state_r;
   lkprt_ram_req_t req_r;
   logic [3:0] wait_r;
   logic [7:0] rd_byte_r;

   // ---------------------------------------------------------------
   // State machine
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state_r <= SEQ_IDLE;
         wait_r <= 4'h0;
      end
      else
      begin
         case (state_r)
            SEQ_IDLE:
            begin
               if (start)
               begin
                  state_r <= SEQ_ISSUE;
               end
            end
            SEQ_ISSUE:
            begin
               state_r <= SEQ_WAIT;
               wait_r <= 4'(ACCESS_CYCLES - 1);
            end
            SEQ_WAIT:
            begin
               if (wait_r == 4'h0)
               begin
                  state_r <= SEQ_DONE;
               end
               else
               begin
                  wait_r <= wait_r - 4'h1;
               end
            end
            default:
            begin
               state_r <= SEQ_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Request and result
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         req_r <= '0;
      end
      else
      begin
         req_r.valid <= (state_r == SEQ_IDLE) && start;
         if (start && (state_r == SEQ_IDLE))
         begin
            req_r.write <= start_write;
            req_r.addr <= addr;
            req_r.wdata <= wdata;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rd_byte_r <= 8'h00;
      end
      else if ((state_r == SEQ_WAIT) && (wait_r == 4'h0))
      begin
         rd_byte_r <= ram_rdata;
      end
   end

   assign ram_req = req_r;
   assign done = (state_r == SEQ_DONE);
   assign rd_byte = rd_byte_r;

endmodule : lkprt_seq

/* logic/lkprt_top.sv */
// APB register port to the real-time clock lookup RAM: address with
// auto-increment, a data byte and self-clearing read and write strobes.
// Assumes an APB master on the same 100 MHz clock; no input needs a
// synchroniser.
//
// What this block does
// - Seven-bit address selects lookup RAM location.
// - Data byte written out or read in.
// - Auto-increment adds one per strobe.
// - Address read returns the advanced value.
// - Strobe bits start a read or write.
// - Strobe holds one until transfer completes.
`timescale 1ns/100ps
module lkprt_top
(
   input wire logic CLK,
   input wire logic SRST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [15:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0] PSTRB,
   output logic PREADY,
   output logic [31:0] PRDATA,
   output logic PSLVERR
);
   import lkprt_pkg::*;

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic [6:0] lookup_address_r;
   logic lookup_auto_increment_r;
   logic [7:0] lookup_data_r;
   logic [1:0] strobe_r;
   logic [1:0] strobe_set;
   logic [1:0] strobe_nxt;
   logic busy;
   logic setup_phase;
   logic wr_take;
   logic lane0;
   lkprt_sel_t setup_sel;
   lkprt_sel_t access_sel;
   logic [31:0] prdata_r;
   logic pslverr_r;
   logic seq_start;
   logic seq_write;
   logic seq_done;
   logic [7:0] seq_rd_byte;
   logic [7:0] ram_rdata;
   lkprt_ram_req_t ram_req;
   logic [6:0] address_nxt;
   logic wr_ok;
   logic addr_wr_en;
   logic data_wr_en;
   logic strobe_wr_en;

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   // Only the three register byte addresses are mapped; any other address,
   // word-aligned or not, is an unmapped access and answers with an error.
   function automatic lkprt_sel_t decode_sel(input logic [15:0] a);
      lkprt_sel_t s;
      s = SEL_NONE;
      if (a == BADDR_ADDR_CTRL)
      begin
         s = SEL_ADDR_CTRL;
      end
      else if (a == BADDR_DATA)
      begin
         s = SEL_DATA;
      end
      else if (a == BADDR_STROBES)
      begin
         s = SEL_STROBES;
      end
      return s;
   endfunction : decode_sel

   assign setup_sel = decode_sel(PADDR);
   assign access_sel = decode_sel(PADDR);
   assign setup_phase = PSEL && !PENABLE;
   // Zero wait states: the access phase completes at its first edge.
   assign PREADY = 1'b1;
   assign wr_take = PSEL && PENABLE && PWRITE;
   // Only byte lane 0 carries register bits; other lanes are ignored.
   assign lane0 = PSTRB[0];

   // strobe busy
   // A transfer in flight locks the port against further changes, so a
   // careless write cannot disturb the address or data mid-access.
   assign busy = |strobe_r;

   // ---------------------------------------------------------------
   // Register write enables
   // ---------------------------------------------------------------
   // One qualifier serves all three registers: the access edge, byte
   // lane 0 and no strobe running. Keeping it in one place means the
   // lockout cannot drift apart from one register to the next.
   function automatic logic write_hit(input logic ok,
                                      input lkprt_sel_t sel,
                                      input lkprt_sel_t want);
      return ok && (sel == want);
   endfunction : write_hit

   assign wr_ok = wr_take && lane0 && !busy;
   assign addr_wr_en = write_hit(wr_ok, access_sel, SEL_ADDR_CTRL);
   assign data_wr_en = write_hit(wr_ok, access_sel, SEL_DATA);
   assign strobe_wr_en = write_hit(wr_ok, access_sel, SEL_STROBES);

   // ---------------------------------------------------------------
   // Address and auto-increment control
   // ---------------------------------------------------------------
   // The field is seven bits wide, so the address wraps from 127 to 0.
   // increment on completion
   always_comb
   begin
      address_nxt = lookup_address_r;
      if (seq_done && lookup_auto_increment_r)
      begin
         address_nxt = lookup_address_r + 7'h01;
      end
   end

   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         lookup_address_r <= RST_ADDR_CTRL[6:0];
         lookup_auto_increment_r <= RST_ADDR_CTRL[AUTO_INC_BIT];
      end
      else if (addr_wr_en)
      begin
         lookup_address_r <= PWDATA[6:0];
         lookup_auto_increment_r <= PWDATA[AUTO_INC_BIT];
      end
      else
      begin
         lookup_address_r <= address_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Data byte
   // ---------------------------------------------------------------
   // data byte register
   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         lookup_data_r <= RST_DATA;
      end
      else if (seq_done && !seq_write)
      begin
         lookup_data_r <= seq_rd_byte;
      end
      else if (data_wr_en)
      begin
         lookup_data_r <= PWDATA[7:0];
      end
   end

   // ---------------------------------------------------------------
   // Strobes
   // ---------------------------------------------------------------
   // strobe start request
   // A write of one sets a strobe while idle; writing zero never aborts.
   // If both bits are written together the write strobe alone is taken,
   // because only one access can run at a time.
   always_comb
   begin
      strobe_set = 2'b00;
      if (strobe_wr_en)
      begin
         if (PWDATA[WR_STROBE_BIT])
         begin
            strobe_set[WR_STROBE_BIT] = 1'b1;
         end
         else if (PWDATA[RD_STROBE_BIT])
         begin
            strobe_set[RD_STROBE_BIT] = 1'b1;
         end
      end
   end

   generate
      for (genvar i = 0; i < 2; i++)
      begin : g_strobe
         always_comb
         begin
            strobe_nxt[i] = strobe_r[i];
            if (strobe_set[i])
            begin
               strobe_nxt[i] = 1'b1;
            end
            else if (seq_done)
            begin
               strobe_nxt[i] = 1'b0;
            end
         end
      end
   endgenerate

   // Reset drops both strobes and abandons any access in flight; the
   // RAM keeps its contents, and a cut write has always landed, as the RAM takes it at the edge after the start edge.
   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         strobe_r <= RST_STROBES[1:0];
      end
      else
      begin
         strobe_r <= strobe_nxt;
      end
   end

   assign seq_start = |strobe_set;
   assign seq_write = strobe_r[WR_STROBE_BIT];

   // ---------------------------------------------------------------
   // Access engine and storage
   // ---------------------------------------------------------------
   // The engine latches address and data at its start edge; the busy
   // lockout keeps them steady for the rest of the access as well.
   lkprt_seq lkprt_seq_i
   (
      .clk(CLK),
      .srst(SRST),
      .start(seq_start),
      .start_write(strobe_set[WR_STROBE_BIT]),
      .addr(lookup_address_r),
      .wdata(lookup_data_r),
      .ram_rdata(ram_rdata),
      .ram_req(ram_req),
      .done(seq_done),
      .rd_byte(seq_rd_byte)
   );

   lkprt_ram lkprt_ram_i
   (
      .clk(CLK),
      .req(ram_req),
      .rdata(ram_rdata)
   );

   // ---------------------------------------------------------------
   // Read data and error response
   // ---------------------------------------------------------------
   // Read data is captured in the setup cycle so that it comes from a
   // flip-flop; it reflects the state at that edge.
   // A read of the data byte while a read strobe runs returns the old
   // byte, so software must see the strobe clear before fetching it.
   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         prdata_r <= 32'h0000_0000;
      end
      else if (setup_phase && !PWRITE)
      begin
         if (setup_sel == SEL_ADDR_CTRL)
         begin
            prdata_r <= {24'h00_0000, lookup_auto_increment_r,
                         lookup_address_r};
         end
         else if (setup_sel == SEL_DATA)
         begin
            prdata_r <= {24'h00_0000, lookup_data_r};
         end
         else if (setup_sel == SEL_STROBES)
         begin
            prdata_r <= {30'h0000_0000, strobe_r};
         end
         else
         begin
            prdata_r <= 32'h0000_0000;
         end
      end
   end

   // The error flag is judged at setup, like the read data, so both
   // stand together through the access phase.
   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         pslverr_r <= 1'b0;
      end
      else if (setup_phase)
      begin
         pslverr_r <= (setup_sel == SEL_NONE);
      end
   end

   assign PRDATA = prdata_r;
   assign PSLVERR = pslverr_r;

endmodule : lkprt_top

/* dv/lkprt_monitor.sv */
// Checker for the lookup RAM access port, watching only the APB pins.
// Assumes the design answers with zero wait states on one clock.
`timescale 1ns/100ps
module lkprt_monitor
   import lkprt_pkg::*;
(
   input wire logic CLK,
   input wire logic SRST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [15:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0] PSTRB,
   input wire logic PREADY,
   input wire logic [31:0] PRDATA,
   input wire logic PSLVERR
);
   // ---------------------------------------------------------------
   // Shadow of the busy window and the address register
   // ---------------------------------------------------------------
   logic [2:0] cnt_r;
   logic [7:0] addr_r;
   logic wr_ok;
   logic setup_rd;
   logic mapped;
   assign wr_ok = PSEL && PENABLE && PWRITE && PSTRB[0] && cnt_r == 3'h0;
   assign setup_rd = PSEL && !PENABLE && !PWRITE;
   assign mapped = PADDR == BADDR_ADDR_CTRL || PADDR == BADDR_DATA ||
      PADDR == BADDR_STROBES;

   // The strobe clears five edges after the write that sets it, so the
   // count is non-zero at exactly the edges at which the port is busy.
   always_ff @(posedge CLK)
   begin
      if (SRST)
         cnt_r <= 3'h0;
      else if (wr_ok && PADDR == BADDR_STROBES && PWDATA[1:0] != 2'h0)
         cnt_r <= 3'h5;
      else if (cnt_r != 3'h0)
         cnt_r <= cnt_r - 3'h1;
   end

   always_ff @(posedge CLK)
   begin
      if (SRST)
         addr_r <= 8'h00;
      else if (wr_ok && PADDR == BADDR_ADDR_CTRL)
         addr_r <= PWDATA[7:0];
      else if (cnt_r == 3'h1 && addr_r[7])
         addr_r <= {1'b1, addr_r[6:0] + 7'h01};
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (SRST);

   chk_ready_zero_wait: assert property (PSEL |-> PREADY)
      else $error("Slave inserted a wait state.");
   chk_upper_bits_zero: assert property
      (PSEL && PENABLE |-> PRDATA[31:8] == 24'h00_0000)
      else $error("Read data above bit 7 is not zero.");
   chk_unmapped_err: assert property
      (PSEL && !PENABLE && !mapped |=> PSLVERR)
      else $error("Unmapped address gave no error.");
   chk_mapped_no_err: assert property
      (PSEL && !PENABLE && mapped |=> !PSLVERR)
      else $error("Mapped address gave an error.");
   chk_strobe_held_busy: assert property
      (setup_rd && PADDR == BADDR_STROBES && cnt_r != 3'h0
      |=> PRDATA[1:0] != 2'h0)
      else $error("Strobe cleared before the access finished.");
   chk_strobe_self_clear: assert property
      (setup_rd && PADDR == BADDR_STROBES && cnt_r == 3'h0
      |=> PRDATA[7:0] == 8'h00)
      else $error("Strobe still set after the access.");
   chk_addr_read_back: assert property
      (setup_rd && PADDR == BADDR_ADDR_CTRL && cnt_r == 3'h0
      |=> PRDATA[7:0] == addr_r)
      else $error("Address readback differs from expectation.");
   chk_rdata_holds: assert property
      (!PSEL |=> $stable(PRDATA))
      else $error("Read data changed outside a transfer.");
endmodule : lkprt_monitor

bind lkprt_top lkprt_monitor lkprt_monitor_i
(
   .CLK(CLK),
   .SRST(SRST),
   .PSEL(PSEL),
   .PENABLE(PENABLE),
   .PWRITE(PWRITE),
   .PADDR(PADDR),
   .PWDATA(PWDATA),
   .PSTRB(PSTRB),
   .PREADY(PREADY),
   .PRDATA(PRDATA),
   .PSLVERR(PSLVERR)
);

/* dv/lkprt_top_tb.sv */
// Self-checking bench for the lookup RAM access port over APB.
// Assumes the bound checker and zero-wait-state reads.
`timescale 1ns/100ps
module lkprt_top_tb;
   import lkprt_pkg::*;
   typedef struct {string nm; logic [32:0] v;} lkprt_note_t;
   logic clk, srst, psel, penable, pwrite, pready, pslverr;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb, strb;
   logic [7:0] mem [0:3];
   logic [6:0] a;
   logic [7:0] d;
   lkprt_note_t note_q[$];
   lkprt_note_t cur;
   int miscompares, checked;
`define CMP(nm, e, s) begin checked++; if ((e) !== (s)) begin miscompares++; \
   $display("MISMATCH %s expected %h seen %h", nm, e, s); end end

   lkprt_top lkprt_top_i (.CLK(clk), .SRST(srst), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PSTRB(pstrb), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict

   // The request is held until pready is seen high at a rising edge.
   task automatic apb(input logic wr, input logic [15:0] ad,
      input logic [31:0] wd, input logic [32:0] e, input string nm);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= wd;
      pstrb <= strb;
      if (!wr)
         note_q.push_back('{nm, e});
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1)
      begin
         miscompares++;
         print_verdict();
      end
   endtask : apb

   task automatic wr(input logic [15:0] ad, input logic [31:0] wd);
      apb(1'b1, ad, wd, 33'h0_0000_0000, "");
   endtask : wr

   task automatic rd(input logic [15:0] ad, input logic [7:0] e, string nm);
      apb(1'b0, ad, 32'h0000_0000, {25'h000_0000, e}, nm);
   endtask : rd

   task automatic idle(input int n);
      psel <= 1'b0;
      penable <= 1'b0;
      repeat (n) @(posedge clk);
   endtask : idle

   // A write to the address while busy must be ignored.
   task automatic access(input logic [7:0] s);
      wr(BADDR_STROBES, {24'h00_0000, s});
      rd(BADDR_STROBES, s, "strobes busy");
      wr(BADDR_ADDR_CTRL, 32'h0000_0055);
      idle(2);
      rd(BADDR_STROBES, 8'h00, "strobes done");
   endtask : access

   always @(posedge clk)
   begin
      if (psel && penable && pready === 1'b1 && !pwrite)
      begin
         if (note_q.size() == 0)
         begin
            miscompares++;
            $display("MISMATCH read expected none seen %h", prdata);
         end
         else
         begin
            cur = note_q.pop_front();
            `CMP(cur.nm, cur.v, {pslverr, prdata})
         end
      end
   end

   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      srst = 1'b1;
      miscompares = 0;
      checked = 0;
      strb = 4'hf;
      void'($urandom(8974));
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      rd(BADDR_ADDR_CTRL, 8'h00, "address reset");
      rd(BADDR_DATA, 8'h00, "data reset");
      rd(BADDR_STROBES, 8'h00, "strobes reset");
      wr(BADDR_STROBES + 16'h0004, 32'h0000_00ff);
      apb(1'b0, BADDR_STROBES + 16'h0004, 32'h0000_0000,
         {1'b1, 32'h0000_0000}, "unmapped");
      for (int i = 0; i < 4; i++)
      begin
         a = 7'($urandom());
         d = 8'($urandom());
         wr(BADDR_ADDR_CTRL, {25'h000_0000, a});
         wr(BADDR_DATA, {24'h00_0000, d});
         access(8'h01);
         wr(BADDR_DATA, 32'h0000_0000);
         access(8'h02);
         rd(BADDR_DATA, d, "data fetched");
         rd(BADDR_ADDR_CTRL, {1'b0, a}, "address kept");
      end
      // Start near the top so auto-increment wraps from 127 to 0.
      wr(BADDR_ADDR_CTRL, 32'h0000_00fe);
      for (int i = 0; i < 4; i++)
      begin
         mem[i] = 8'($urandom());
         wr(BADDR_DATA, {24'h00_0000, mem[i]});
         access(8'h01);
         rd(BADDR_ADDR_CTRL, {1'b1, 7'h7e + 7'(i) + 7'h01}, "auto");
      end
      wr(BADDR_ADDR_CTRL, 32'h0000_00fe);
      for (int i = 0; i < 4; i++)
      begin
         access(8'h02);
         rd(BADDR_DATA, mem[i], "auto data");
         rd(BADDR_ADDR_CTRL, {1'b1, 7'h7e + 7'(i) + 7'h01}, "auto");
      end
      // Lane 0 disabled: the write must leave the address alone.
      strb = 4'he;
      wr(BADDR_ADDR_CTRL, 32'h0000_0033);
      strb = 4'hf;
      rd(BADDR_ADDR_CTRL, 8'h82, "lane0 off");
      // Both strobes at once: only the write runs.
      wr(BADDR_ADDR_CTRL, 32'h0000_0011);
      wr(BADDR_DATA, 32'h0000_00a5);
      wr(BADDR_STROBES, 32'h0000_0003);
      rd(BADDR_STROBES, 8'h01, "both strobes");
      idle(6);
      wr(BADDR_DATA, 32'h0000_0000);
      access(8'h02);
      rd(BADDR_DATA, 8'ha5, "both wrote");
      // Reset in mid-access: every register returns to zero.
      wr(BADDR_ADDR_CTRL, 32'h0000_0085);
      wr(BADDR_STROBES, 32'h0000_0001);
      srst <= 1'b1;
      idle(2);
      srst <= 1'b0;
      @(posedge clk);
      rd(BADDR_ADDR_CTRL, 8'h00, "address reset again");
      rd(BADDR_DATA, 8'h00, "data reset again");
      rd(BADDR_STROBES, 8'h00, "strobes reset again");
      access(8'h02);
      rd(BADDR_DATA, mem[2], "after reset");
      idle(2);
      if (note_q.size() != 0)
         miscompares++;
      print_verdict();
   end
endmodule : lkprt_top_tb
